// ---- hw/det_chan_pkg.sv ----
// package: constants and carriers for the detector channel status block
package det_chan_pkg;

    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int NUM_POINTS = 16;
    localparam int CLOCK_HZ = 125_000_000;
    localparam int SETTLE_TIME_S = 5;
    localparam int TEST_INTERVAL_S = 15;
    localparam longint SETTLE_CYCLES_L = longint'(SETTLE_TIME_S) * CLOCK_HZ;
    localparam longint TEST_CYCLES_L = longint'(TEST_INTERVAL_S) * CLOCK_HZ;
    localparam int SETTLE_CYCLES = int'(SETTLE_CYCLES_L);
    localparam int TEST_CYCLES = int'(TEST_CYCLES_L);
    localparam int CNT_W = 32;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] RST_ONES = 16'hffff;

    // ------------------------------------------------------------
    // per-point channel phase
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PH_LIVE = 2'b00,
        PH_RESET = 2'b01,
        PH_SETTLE = 2'b11
    } phase_e;

    // field condition of all points, from the comparators
    typedef struct packed
    {
        logic [15:0] alarm;
        logic [15:0] open_ckt;
        logic [15:0] short_ckt;
    } field_s;

    // processor control bits for all points
    typedef struct packed
    {
        logic [15:0] chan_reset;
        logic [15:0] alarm_indicator_force;
        logic [15:0] fault_lamp_mask;
        logic [15:0] unconnected;
    } ctrl_s;

endpackage : det_chan_pkg

// ---- hw/det_chan_point.sv ----
// one point: reset phase, settle counter and frozen input value
module det_chan_point
    import det_chan_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES
)
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_chan_reset,
    input wire logic i_live_alarm,
    output logic o_loop_power,
    output logic o_frozen,
    output logic o_held_value
);

    phase_e phase_ff;
    logic [CNT_W-1:0] settle_ff;
    logic held_ff;

    // ------------------------------------------------------------
    // phase sequence: live -> reset -> settle -> live
    // ------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
            phase_ff <= PH_LIVE;
        else if (i_ce)
        begin
            case (phase_ff)
                PH_LIVE:
                    if (i_chan_reset)
                        phase_ff <= PH_RESET;
                PH_RESET:
                    if (!i_chan_reset)
                        phase_ff <= PH_SETTLE;
                PH_SETTLE:
                    if (i_chan_reset)
                        phase_ff <= PH_RESET;
                    else if (settle_ff == CNT_W'(SETTLE_CNT - 1))
                        phase_ff <= PH_LIVE;
                default:
                    phase_ff <= PH_LIVE;
            endcase
        end
    end

    // settle counter runs only while settling
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
            settle_ff <= '0;
        else if (i_ce)
        begin
            if (phase_ff == PH_SETTLE)
                settle_ff <= settle_ff + CNT_W'(1);
            else
                settle_ff <= '0;
        end
    end

    // capture the value reported just before reset
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
            held_ff <= 1'b0;
        else if (i_ce && phase_ff == PH_LIVE)
            held_ff <= i_live_alarm;
    end

    assign o_loop_power = !i_chan_reset;
    assign o_frozen = (phase_ff != PH_LIVE);
    assign o_held_value = held_ff;

    a_settle_len: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (phase_ff == PH_SETTLE && settle_ff == CNT_W'(SETTLE_CNT - 1)
         && i_ce && !i_chan_reset) |=> phase_ff == PH_LIVE)
        else $error("settle did not end on time");

    a_held_stable: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        o_frozen |=> $stable(held_ff))
        else $error("frozen value changed");

endmodule : det_chan_point

// ---- hw/det_chan_status.sv ----
// top: status and control of sixteen fire detector points

module det_chan_status
    import det_chan_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES,
    parameter int TEST_CNT = TEST_CYCLES
)
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire field_s i_field,
    input wire ctrl_s i_ctrl,
    output logic [15:0] o_input_word,
    output logic [15:0] o_line_ok,
    output logic [15:0] o_loop_power,
    output logic [15:0] o_alarm_lamp,
    output logic [15:0] o_fault_lamp,
    output logic o_self_test
);

    // ------------------------------------------------------------
    // field input synchronisers
    // ------------------------------------------------------------
    field_s meta_ff;
    field_s field_ff;
    logic [15:0] frozen;
    logic [15:0] held;
    logic [15:0] nxt_input;
    logic [15:0] nxt_line_ok;
    logic [15:0] nxt_alarm;
    logic [15:0] nxt_fault;
    logic [CNT_W-1:0] test_ff;

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            meta_ff <= '0;
            field_ff <= '0;
        end
        else if (i_ce)
        begin
            meta_ff <= i_field;
            field_ff <= meta_ff;
        end
    end

    // ------------------------------------------------------------
    // per-point reset sequencing
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_POINTS; g++)
        begin : g_pt
            det_chan_point #(.SETTLE_CNT(SETTLE_CNT)) u_pt
            (
                .i_clock(i_clock),
                .i_rst_b(i_rst_b),
                .i_ce(i_ce),
                .i_chan_reset(i_ctrl.chan_reset[g]),
                .i_live_alarm(field_ff.alarm[g]),
                .o_loop_power(o_loop_power[g]),
                .o_frozen(frozen[g]),
                .o_held_value(held[g])
            );
        end
    endgenerate

    // next values of the reported and displayed bits
    always_comb
    begin
        nxt_input = (frozen & held) | (~frozen & field_ff.alarm);
        nxt_line_ok = ~(field_ff.open_ckt | field_ff.short_ckt)
                      & ~i_ctrl.chan_reset;
        nxt_alarm = (i_ctrl.alarm_indicator_force | field_ff.alarm)
                    & ~i_ctrl.chan_reset;
        nxt_fault = (~nxt_line_ok | i_ctrl.unconnected)
                    & ~i_ctrl.fault_lamp_mask;
    end

    // ------------------------------------------------------------
    // registered outputs, point one in bit zero
    // ------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            o_input_word <= RST_WORD;
            o_line_ok <= RST_ONES;
            o_alarm_lamp <= RST_WORD;
            o_fault_lamp <= RST_WORD;
        end
        else if (i_ce)
        begin
            o_input_word <= nxt_input;
            o_line_ok <= nxt_line_ok;
            o_alarm_lamp <= nxt_alarm;
            o_fault_lamp <= nxt_fault;
        end
    end

    // ------------------------------------------------------------
    // periodic self-test strobe
    // ------------------------------------------------------------

    // true when a free-running count has reached its last value
    function automatic logic at_last(logic [CNT_W-1:0] cnt, int limit);
        return cnt == CNT_W'(limit - 1);
    endfunction : at_last

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            test_ff <= '0;
            o_self_test <= 1'b0;
        end
        else if (i_ce)
        begin
            o_self_test <= at_last(test_ff, TEST_CNT);
            if (at_last(test_ff, TEST_CNT))
                test_ff <= '0;
            else
                test_ff <= test_ff + CNT_W'(1);
        end
        else
            o_self_test <= 1'b0;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a reset seen on point one, then seen dropped at the next edge
    sequence s_reset_held;
        i_ce && i_ctrl.chan_reset[0];
    endsequence

    sequence s_reset_gone;
        i_ce && !i_ctrl.chan_reset[0];
    endsequence

    a_mask_dark: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && i_ctrl.fault_lamp_mask[0]) |=> !o_fault_lamp[0])
        else $error("masked fault lamp lit");

    a_spare_lamp: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && i_ctrl.unconnected[0] && !i_ctrl.fault_lamp_mask[0])
        |=> o_fault_lamp[0])
        else $error("spare point fault lamp dark");

    a_reset_fault: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && i_ctrl.chan_reset[0]) |=> !o_line_ok[0])
        else $error("no line fault during reset");

    a_reset_lamp: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && i_ctrl.chan_reset[0]) |=> !o_alarm_lamp[0])
        else $error("alarm lamp lit during reset");

    a_power_off: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_ctrl.chan_reset[0] |-> !o_loop_power[0])
        else $error("loop powered during reset");

    a_power_back: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        !i_ctrl.chan_reset[15] |-> o_loop_power[15])
        else $error("loop unpowered without reset");

    a_force_lamp: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && i_ctrl.alarm_indicator_force[0] && !i_ctrl.chan_reset[0])
        |=> o_alarm_lamp[0])
        else $error("forced lamp dark");

    a_fault_lamp: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && (field_ff.open_ckt[0] | field_ff.short_ckt[0])
         && !i_ctrl.fault_lamp_mask[0]) |=> o_fault_lamp[0])
        else $error("fault lamp dark on wiring fault");

    a_wiring_fault: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && (field_ff.open_ckt[15] || field_ff.short_ckt[15]))
        |=> !o_line_ok[15])
        else $error("line ok set on wiring fault");

    a_line_restore: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && !field_ff.open_ckt[0] && !field_ff.short_ckt[0]
         && !i_ctrl.chan_reset[0]) |=> o_line_ok[0])
        else $error("line ok not restored");

    a_live_input: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && !frozen[0]) |=> o_input_word[0] == $past(field_ff.alarm[0]))
        else $error("input word not live");

    a_word_msb: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && !frozen[15])
        |=> o_input_word[15] == $past(field_ff.alarm[15]))
        else $error("point sixteen not in top bit");

    a_input_frozen: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_ce && frozen[0]) |=> $stable(o_input_word[0]))
        else $error("reported input moved while frozen");

    a_lamp_live: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        s_reset_held ##1 s_reset_gone |=> o_alarm_lamp[0] ==
        ($past(i_ctrl.alarm_indicator_force[0]) | $past(field_ff.alarm[0])))
        else $error("alarm lamp not live after reset");

    a_word_settle: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        s_reset_held ##1 s_reset_gone |=> $stable(o_input_word[0]))
        else $error("input word live right after reset");

    a_test_pulse: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (TEST_CNT > 1 && o_self_test) |=> !o_self_test)
        else $error("self test strobe longer than one cycle");

endmodule : det_chan_status

// ---- sim/proc_model.sv ----
// processor model: drives the control bits, keeps each reset long enough
module proc_model
    import det_chan_pkg::*;
#(
    parameter int MIN_HOLD = 4
)
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire ctrl_s i_req,
    output ctrl_s o_ctrl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] keep_ff;
    int cnt_ff [16];

    // requested bits, a started reset held up by keep_ff
    always_comb
    begin
        o_ctrl = i_req;
        o_ctrl.chan_reset = i_req.chan_reset | keep_ff;
    end

    // count how long each reset has stood so far
    always_ff @(posedge i_clock)
    begin
        for (int n = 0; n < 16; n++)
        begin
            if (!i_rst_b)
            begin
                cnt_ff[n] <= 0;
                keep_ff[n] <= 1'b0;
            end
            else
            begin
                cnt_ff[n] <= o_ctrl.chan_reset[n] ? cnt_ff[n] + 1 : 0;
                keep_ff[n] <= o_ctrl.chan_reset[n] && cnt_ff[n] < MIN_HOLD - 1;
            end
        end
    end
endmodule : proc_model

// ---- sim/detector_channel_reset_status_tb_top.sv ----
// testbench: random and corner stimulus for the detector channel block
module detector_channel_reset_status_tb_top
    import det_chan_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 20;
    localparam int TEST = 50;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ce = 1'b1;
    field_s fld = '0;
    ctrl_s req = '0;
    ctrl_s ctrl;
    logic [15:0] word, ok, pwr, alamp, flamp, a, b, r;
    logic tst;
    int bad_count = 0;
    int compares = 0;
    int gap;

    // clock at 125 MHz
    initial
    begin
        forever #4 i_clock = ~i_clock;
    end

    proc_model i_proc (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_req(req), .o_ctrl(ctrl));

    det_chan_status #(.SETTLE_CNT(SETTLE), .TEST_CNT(TEST)) i_dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_ce(i_ce),
        .i_field(fld), .i_ctrl(ctrl), .o_input_word(word),
        .o_line_ok(ok), .o_loop_power(pwr), .o_alarm_lamp(alamp),
        .o_fault_lamp(flamp), .o_self_test(tst));

    // expected lamps from field, force, mask and reset bits
    function automatic logic [15:0] exp_alamp(logic [15:0] al, fo, rs);
        return (al | fo) & ~rs;
    endfunction : exp_alamp

    function automatic logic [15:0] exp_flamp(logic [15:0] lok, un, mk);
        return (~lok | un) & ~mk;
    endfunction : exp_flamp

    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wait_n(int n);
        repeat (n) @(negedge i_clock);
    endtask : wait_n

    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    // watchdog against a hang
    initial
    begin
        #100000;
        bad_count++;
        end_sim();
    end

    // main sequence
    initial
    begin
        void'($urandom(18884));
        wait_n(6);
        i_rst_b = 1'b1;
        // random field, force and mask, last pass clears all faults
        for (int i = 0; i < 24; i++)
        begin
            fld = {16'($urandom), 16'($urandom & $urandom), 16'($urandom)};
            if (i == 23)
                fld = '0;
            req.alarm_indicator_force = 16'($urandom);
            req.fault_lamp_mask = 16'($urandom);
            wait_n(4);
            a = ~(fld.open_ckt | fld.short_ckt);
            chk("input_word", fld.alarm, word);
            chk("line_ok", a, ok);
            b = exp_alamp(fld.alarm, req.alarm_indicator_force, 16'h0000);
            chk("alarm_lamp", b, alamp);
            r = exp_flamp(a, 16'h0000, req.fault_lamp_mask);
            chk("fault_lamp", r, flamp);
        end
        // spare points, lamp on unless masked
        req.unconnected = 16'hffff;
        req.fault_lamp_mask = 16'($urandom);
        wait_n(2);
        chk("spare_fault_lamp", ~req.fault_lamp_mask, flamp);
        req = '0;
        // channel reset with the field changing meanwhile
        a = 16'($urandom);
        fld.alarm = a;
        wait_n(4);
        b = ~a;
        r = 16'($urandom) | 16'h8001;
        fld.alarm = b;
        req.chan_reset = r;
        #1;
        chk("loop_power", ~r, pwr);
        wait_n(4);
        chk("reset_alarm_lamp", b & ~r, alamp);
        chk("reset_line_ok", ~r, ok);
        chk("reset_input_word", (a & r) | (b & ~r), word);
        req.chan_reset = 16'h0000;
        #1;
        chk("power_back", 16'hffff, pwr);
        wait_n(2);
        chk("live_alarm_lamp", b, alamp);
        wait_n(3);
        chk("settle_word", (a & r) | (b & ~r), word);
        wait_n(SETTLE + 2);
        chk("settled_word", b, word);
        // spacing of the self test strobe
        for (int i = 0; i < 200 && tst !== 1'b1; i++)
            @(negedge i_clock);
        gap = 0;
        do
        begin
            @(negedge i_clock);
            gap++;
        end
        while (tst !== 1'b1 && gap < 200);
        chk("self_test_gap", 16'(TEST), 16'(gap));
        // clock enable low freezes the reported word
        i_ce = 1'b0;
        fld.alarm = a;
        wait_n(6);
        chk("frozen_word", b, word);
        i_ce = 1'b1;
        wait_n(4);
        chk("resumed_word", a, word);
        end_sim();
    end
endmodule : detector_channel_reset_status_tb_top
